/* core/nvio_pkg.sv */
/*
 * constants, field layout, defaults and state encoding of the
 * nine-pin nonvolatile I/O expander with its two-wire slave port.
 * assumes a 20 MHz reference clock; used by every core file.
 */
package nvio_pkg;
    // ========================================================
    // register offsets
    localparam logic [7:0] ADR_USER_END = 8'h3F;
    localparam logic [7:0] ADR_PU_LO = 8'hF0;
    localparam logic [7:0] ADR_PU_HI = 8'hF1;
    localparam logic [7:0] ADR_CTL_LO = 8'hF2;
    localparam logic [7:0] ADR_CTL_HI = 8'hF3;
    localparam logic [7:0] ADR_CFG = 8'hF4;
    localparam logic [7:0] ADR_NVX_LO = 8'hF5;
    localparam logic [7:0] ADR_NVX_HI = 8'hF7;
    localparam logic [7:0] ADR_LVL_LO = 8'hF8;
    localparam logic [7:0] ADR_LVL_HI = 8'hF9;
    localparam logic [7:0] ADR_SRAM_LO = 8'hFA;
    // ========================================================
    // fields and factory defaults
    localparam int CFG_SEE_BIT = 0;
    localparam logic [7:0] RST_PU_LO = 8'h00;
    localparam logic [7:0] RST_PU_HI = 8'h00;
    localparam logic [7:0] RST_CTL_LO = 8'hFF;
    localparam logic [7:0] RST_CTL_HI = 8'h01;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_USER = 8'h00;
    // ========================================================
    // nonvolatile array layout: 64 user bytes, then copies of F0..F7
    localparam int NV_DEPTH = 72;
    localparam int NV_AW = 7;
    localparam logic [3:0] NV_IDX_HI = 4'h8;
    // upper slave address bits, arbitrary value
    localparam logic [3:0] DEV_ADDR_HI = 4'h5;
    // ========================================================
    // timing
    localparam int REF_CLK_HZ = 20_000_000;
    localparam int NV_WRITE_TIME_MS = 10;
    localparam int NV_WRITE_CYC = (NV_WRITE_TIME_MS * REF_CLK_HZ) / 1000;
    // ========================================================
    // slave sequencer states
    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} nvio_state_t;

    // map a bus offset onto the nonvolatile array index
    function automatic logic [NV_AW-1:0] nv_index(input logic [7:0] a);
        nv_index = (a <= ADR_USER_END) ? {1'b0, a[5:0]} : {NV_IDX_HI, a[2:0]};
    endfunction
endpackage

/* core/nvio_sync.sv */
/*
 * two flip-flop synchroniser for a group of pins.
 * assumes each bit is independent; resets to the released level.
 */
module nvio_sync
    import nvio_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    if (W < 1)
    begin : g_chk
        $error("nvio_sync width must be at least one");
    end

    // ========================================================
    // first stage is read only by the second
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            meta_q <= '1;
            o_q <= '1;
        end
        else
        begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

/* core/nvio_nvmem.sv */
/*
 * nonvolatile byte array: user memory plus the stored copies of the
 * shadowed registers. contents survive reset; read data is registered.
 * assumes one write per cycle from the sequencer.
 */
module nvio_nvmem
    import nvio_pkg::*;
#(
    parameter int DEPTH = NV_DEPTH,
    parameter int AW = NV_AW
)
(
    input wire logic i_ref_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [DEPTH];

    if (DEPTH > (1 << AW) || DEPTH < 69)
    begin : g_chk
        $error("nvio_nvmem depth does not fit the layout");
    end

    // ========================================================
    // factory contents
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
            mem[i] = RST_USER;
        mem[nv_index(ADR_PU_LO)] = RST_PU_LO;
        mem[nv_index(ADR_PU_HI)] = RST_PU_HI;
        mem[nv_index(ADR_CTL_LO)] = RST_CTL_LO;
        mem[nv_index(ADR_CTL_HI)] = RST_CTL_HI;
        mem[nv_index(ADR_CFG)] = RST_CFG;
    end

    // write port and registered read port
    always_ff @(posedge i_ref_clk)
    begin
        if (i_we)
            mem[i_waddr] <= i_wdata;
        o_rdata <= mem[i_raddr];
    end
endmodule

/* core/nvio_expander.sv */
/*
 * nine-pin open-drain I/O expander behind a two-wire serial slave.
 * holds the shadow registers, sequences the bus, and programs the
 * nonvolatile array at the stop after a write to user memory, F5..F7, or F0..F4 with SEE clear.
 * assumes scl and sda come from an external master and are sampled
 * here; pins and straps are asynchronous.
 */
module nvio_expander
    import nvio_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic [8:0] i_io,
    output logic [8:0] o_io,
    output logic [8:0] o_io_oe,
    output logic [8:0] o_io_pu_en,
    input wire logic i_addr_strap_0,
    input wire logic i_addr_strap_1,
    input wire logic i_addr_strap_2,
    output logic o_nv_busy
);
    localparam int CW = $clog2(NV_WRITE_CYCLES + 1);

    if (NV_WRITE_CYCLES < 1)
    begin : g_chk
        $error("nv write time must be at least one cycle");
    end

    typedef struct packed {
        nvio_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic is_addr;
        logic rw;
        logic got_ptr;
        logic [7:0] ptr;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic [2:0] bcnt;
        logic [7:0] pu0;
        logic [7:0] pu1;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] cfg;
        logic [5:0][7:0] sram;
        logic pend;
        logic [7:0] pend_addr;
        logic [7:0] pend_data;
        logic we;
        logic busy;
        logic [CW-1:0] wcnt;
        logic [8:0] io_oe;
        logic [8:0] pu_en;
    } nvio_regs_t;

    nvio_regs_t q;
    nvio_regs_t d;
    logic [13:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [8:0] lvl;
    logic [2:0] straps;
    logic [7:0] rdata;
    logic [NV_AW-1:0] raddr;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic see;

    // ========================================================
    // pin sampling
    nvio_sync #(.W(14)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_d({i_addr_strap_2, i_addr_strap_1, i_addr_strap_0, i_io, i_sda, i_scl}),
        .o_q(pins_s)
    );

    // split synchronised pins; levels feed the status bytes
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign lvl = pins_s[10:2];
    assign straps = pins_s[13:11];

    // bus events from the sampled lines
    assign scl_rise = scl_s & ~q.scl_p;
    assign scl_fall = ~scl_s & q.scl_p;
    assign start_det = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_det = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign see = q.cfg[CFG_SEE_BIT];

    // ========================================================
    // nonvolatile array
    assign raddr = (q.st == ST_BOOT) ? {NV_IDX_HI, q.bcnt} : nv_index(q.ptr);

    nvio_nvmem u_nvmem (
        .i_ref_clk(i_ref_clk),
        .i_we(q.we),
        .i_waddr(nv_index(q.pend_addr)),
        .i_wdata(q.pend_data),
        .i_raddr(raddr),
        .o_rdata(rdata)
    );

    // ========================================================
    // read data for one offset
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input nvio_regs_t s,
                                           input logic [7:0] nv, input logic [8:0] lv);
        logic [2:0] si;
        si = 3'(a - ADR_SRAM_LO);
        if (a <= ADR_USER_END || (a >= ADR_NVX_LO && a <= ADR_NVX_HI))
            rd_byte = nv;
        else if (a == ADR_PU_LO)
            rd_byte = s.pu0;
        else if (a == ADR_PU_HI)
            rd_byte = s.pu1;
        else if (a == ADR_CTL_LO)
            rd_byte = s.ctl0;
        else if (a == ADR_CTL_HI)
            rd_byte = s.ctl1;
        else if (a == ADR_CFG)
            rd_byte = s.cfg;
        else if (a == ADR_LVL_LO)
            rd_byte = lv[7:0];
        else if (a == ADR_LVL_HI)
            rd_byte = {7'h00, lv[8]};
        else if (a >= ADR_SRAM_LO)
            rd_byte = s.sram[si];
        else
            rd_byte = 8'h00;
    endfunction

    // ========================================================
    // sequencer next state
    always_comb
    begin
        logic [7:0] b;
        b = rd_byte(q.ptr, q, rdata, lvl);
        d = q;
        d.we = 1'b0;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        // pin outputs follow the shadow copies
        d.io_oe = ~{q.ctl1[0], q.ctl0};
        d.pu_en = {q.pu1[0], q.pu0};
        // write-time counter
        if (q.busy)
        begin
            if (q.wcnt == '0)
                d.busy = 1'b0;
            else
                d.wcnt = q.wcnt - 1'b1;
        end
        case (q.st)
            ST_BOOT:
            begin
                // restore the shadows from their stored copies
                d.bcnt = q.bcnt + 3'h1;
                case (q.bcnt)
                    3'h1: d.pu0 = rdata;
                    3'h2: d.pu1 = rdata;
                    3'h3: d.ctl0 = rdata;
                    3'h4: d.ctl1 = rdata;
                    3'h5:
                    begin
                        d.cfg = rdata;
                        d.st = ST_IDLE;
                    end
                    default: ;
                endcase
            end
            ST_IDLE: ;
            ST_RX:
            begin
                if (scl_rise && q.bitcnt < 4'h8)
                begin
                    d.shreg = {q.shreg[6:0], sda_s};
                    d.bitcnt = q.bitcnt + 4'h1;
                end
                else if (scl_fall && q.bitcnt == 4'h8)
                begin
                    d.st = ST_RX_ACK;
                    d.sda_oe = 1'b1;
                    if (q.is_addr)
                    begin
                        d.is_addr = 1'b0;
                        d.rw = q.shreg[0];
                        if (q.shreg[7:1] != {DEV_ADDR_HI, straps} || q.busy)
                        begin
                            d.st = ST_IDLE;
                            d.sda_oe = 1'b0;
                        end
                    end
                    else if (!q.got_ptr)
                    begin
                        d.ptr = q.shreg;
                        d.got_ptr = 1'b1;
                    end
                    else
                    begin
                        d.ptr = q.ptr + 8'h01;
                        if (q.ptr <= ADR_USER_END || (q.ptr >= ADR_NVX_LO && q.ptr <= ADR_NVX_HI))
                        begin
                            d.pend = 1'b1;
                            d.pend_addr = q.ptr;
                            d.pend_data = q.shreg;
                        end
                        else if (q.ptr >= ADR_PU_LO && q.ptr <= ADR_CFG)
                        begin
                            if (q.ptr == ADR_PU_LO) d.pu0 = q.shreg;
                            if (q.ptr == ADR_PU_HI) d.pu1 = q.shreg;
                            if (q.ptr == ADR_CTL_LO) d.ctl0 = q.shreg;
                            if (q.ptr == ADR_CTL_HI) d.ctl1 = q.shreg;
                            if (q.ptr == ADR_CFG) d.cfg = q.shreg;
                            if (!see)
                            begin
                                d.pend = 1'b1;
                                d.pend_addr = q.ptr;
                                d.pend_data = q.shreg;
                            end
                        end
                        else if (q.ptr >= ADR_SRAM_LO)
                            d.sram[3'(q.ptr - ADR_SRAM_LO)] = q.shreg;
                    end
                end
            end
            ST_RX_ACK:
            begin
                if (scl_fall)
                begin
                    d.bitcnt = 4'h0;
                    if (q.rw)
                    begin
                        d.st = ST_TX;
                        d.shreg = b;
                        d.sda_oe = ~b[7];
                    end
                    else
                    begin
                        d.st = ST_RX;
                        d.sda_oe = 1'b0;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_fall)
                begin
                    if (q.bitcnt == 4'h7)
                    begin
                        d.sda_oe = 1'b0;
                        d.st = ST_TX_ACK;
                    end
                    else
                    begin
                        d.shreg = {q.shreg[6:0], 1'b0};
                        d.sda_oe = ~q.shreg[6];
                        d.bitcnt = q.bitcnt + 4'h1;
                    end
                end
            end
            ST_TX_ACK:
            begin
                if (scl_rise)
                begin
                    if (sda_s)
                        d.st = ST_IDLE;
                    else
                    begin
                        d.ptr = q.ptr + 8'h01;
                        d.bitcnt = 4'h8;
                    end
                end
                else if (scl_fall && q.bitcnt == 4'h8)
                begin
                    d.st = ST_TX;
                    d.bitcnt = 4'h0;
                    d.shreg = b;
                    d.sda_oe = ~b[7];
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // start and stop override any state but ST_BOOT; clock is never driven
        if (q.st != ST_BOOT && start_det)
        begin
            d.st = ST_RX;
            d.bitcnt = 4'h0;
            d.is_addr = 1'b1;
            d.got_ptr = 1'b0;
            d.sda_oe = 1'b0;
        end
        else if (q.st != ST_BOOT && stop_det)
        begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
            if (q.pend)
            begin
                d.we = 1'b1;
                d.pend = 1'b0;
                d.busy = 1'b1;
                d.wcnt = CW'(NV_WRITE_CYCLES - 1);
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            q <= '0;
            q.st <= ST_BOOT;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.pu0 <= RST_PU_LO;
            q.pu1 <= RST_PU_HI;
            q.ctl0 <= RST_CTL_LO;
            q.ctl1 <= RST_CTL_HI;
            q.cfg <= RST_CFG;
        end
        else
            q <= d;
    end

    // outputs straight from the state flops; open-drain data is always low
    assign o_sda = 1'b0;
    assign o_io = 9'h000;
    assign o_sda_oe = q.sda_oe;
    assign o_io_oe = q.io_oe;
    assign o_io_pu_en = q.pu_en;
    assign o_nv_busy = q.busy;

    // ========================================================
    // checks
    AST_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.st != ST_BOOT && start_det) |=> (q.st == ST_RX && q.bitcnt == 4'h0 && !q.sda_oe))
        else $error("start not taken");
    AST_STOP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.st != ST_BOOT && stop_det && !start_det) |=> (q.st == ST_IDLE && !q.sda_oe))
        else $error("stop not taken");
    AST_SAMPLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.st == ST_RX && scl_rise && q.bitcnt < 4'h8 && !start_det && !stop_det)
        |=> (q.shreg[0] == $past(sda_s) && q.bitcnt == $past(q.bitcnt) + 4'h1))
        else $error("bit not captured on rising clock");
    AST_NOMATCH: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.st == ST_RX && q.is_addr && scl_fall && q.bitcnt == 4'h8 && !start_det
         && !stop_det && q.shreg[7:1] != {DEV_ADDR_HI, straps})
        |=> (q.st == ST_IDLE && !o_sda_oe))
        else $error("foreign address acknowledged");
    AST_DRIVE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $stable({q.ctl1[0], q.ctl0}) |=> (o_io_oe == ~{$past(q.ctl1[0]), $past(q.ctl0)}))
        else $error("pin drive does not follow control bits");
    AST_PULLUP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $stable({q.pu1[0], q.pu0}) |=> (o_io_pu_en == {$past(q.pu1[0]), $past(q.pu0)}))
        else $error("pullups do not follow enable bits");
    AST_COMMIT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.st != ST_BOOT && stop_det && !start_det && q.pend)
        |=> (q.we && o_nv_busy && !q.pend) ##1 (!q.we))
        else $error("write cycle not started at stop");
    AST_NOWAIT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (see && !q.pend && !q.busy && q.st == ST_RX && q.ptr >= ADR_PU_LO && q.ptr <= ADR_CFG)
        |=> !q.pend)
        else $error("shadow-only write queued a nonvolatile cycle");
    AST_BUSY_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (q.busy && q.wcnt != '0) |=> o_nv_busy)
        else $error("write cycle ended early");
endmodule

/* tb/nvio_i2c_master.sv */
/*
 * behavioural two-wire bus master: scl, starts, stops and bytes.
 * assumes the bench resolves sda as an open-drain wire with pullup.
 */
module nvio_i2c_master
(
    input wire logic i_ref_clk,
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // bus timing, half a bit is 4 cycles
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // start, or repeated start from scl low
    task automatic start();
        o_sda = 1'b1;
        hc(4);
        o_scl = 1'b1;
        hc(4);
        o_sda = 1'b0;
        hc(4);
        o_scl = 1'b0;
        hc(4);
    endtask
    // stop; returns at the sda rise so busy is seen from its start
    task automatic stop();
        o_sda = 1'b0;
        hc(4);
        o_scl = 1'b1;
        hc(4);
        o_sda = 1'b1;
    endtask
    // one bit, data moved only while scl low
    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        hc(3);
        o_scl = 1'b1;
        hc(2);
        r = i_sda;
        hc(2);
        o_scl = 1'b0;
        hc(1);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

/* tb/testbench.sv */
/*
 * self-checking bench of the expander over its two-wire port.
 * assumes pins resolve as open drain with pullup and external level.
 */
module testbench
    import nvio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NVC = 20;
    logic clk, rst, scl, sda_m, sda, sda_oe, busy, sda_o;
    logic [8:0] ext, io_oe, io_pu, lvl, io_o;
    logic [2:0] strap;
    logic [7:0] rdat;
    int n_errors, total_checks;
    // ========================================
    // wires and instances
    assign sda = sda_m & ~sda_oe;
    assign lvl = ~io_oe & (io_pu | ext);
    nvio_expander #(.NV_WRITE_CYCLES(NVC)) dut_u (.i_ref_clk(clk), .i_rst(rst),
        .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_io(lvl), .o_io(io_o),
        .o_io_oe(io_oe), .o_io_pu_en(io_pu), .i_addr_strap_0(strap[0]),
        .i_addr_strap_1(strap[1]), .i_addr_strap_2(strap[2]), .o_nv_busy(busy));
    nvio_i2c_master mst_u (.i_ref_clk(clk), .o_scl(scl), .o_sda(sda_m), .i_sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ========================================
    // checks and bus helpers
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t ack %b expected %b", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    // counts busy cycles after a stop, bounded
    task automatic nv_wait(input int exp);
        int n;
        n = 0;
        for (int k = 0; k < 200; k++)
        begin
            @(negedge clk);
            if (busy === 1'b1)
                n++;
            if (n > 0 && busy !== 1'b1)
                break;
        end
        chk(9'(n), 9'(exp));
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d, input int nb);
        logic a;
        mst_u.start();
        mst_u.wr_byte({DEV_ADDR_HI, strap, 1'b0}, a);
        chk_bit(a, 1'b1);
        mst_u.wr_byte(off, a);
        chk_bit(a, 1'b1);
        mst_u.wr_byte(d, a);
        chk_bit(a, 1'b1);
        mst_u.stop();
        nv_wait(nb);
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        logic a;
        mst_u.start();
        mst_u.wr_byte({DEV_ADDR_HI, strap, 1'b0}, a);
        mst_u.wr_byte(off, a);
        mst_u.start();
        mst_u.wr_byte({DEV_ADDR_HI, strap, 1'b1}, a);
        chk_bit(a, 1'b1);
        mst_u.rd_byte(1'b1, d);
        mst_u.stop();
        mst_u.hc(8);
    endtask
    // ========================================
    // scenarios
    task automatic s_nv();
        chk(io_oe, 9'h000);
        chk(io_pu, 9'h000);
        chk({8'h00, sda_o}, 9'h000);
        chk(io_o, 9'h000);
        wr(8'hF2, 8'h00, NVC);
        chk(io_oe, 9'h0FF);
        do_reset();
        chk(io_oe, 9'h0FF);
    endtask
    task automatic s_pu();
        wr(8'hF0, 8'hA5, NVC);
        wr(8'hF1, 8'h01, NVC);
        chk(io_pu, 9'h1A5);
        rd(8'hF0, rdat);
        chk({1'b0, rdat}, 9'h0A5);
    endtask
    // set SEE, then a shadow only write, then pin levels with mixed drive
    task automatic s_see();
        wr(8'hF4, 8'h01, NVC);
        wr(8'hF2, 8'h3C, 0);
        chk(io_oe, 9'h0C3);
        ext = 9'h00F;
        rd(8'hF8, rdat);
        chk({1'b0, rdat}, 9'h02C);
        rd(8'hF9, rdat);
        chk({1'b0, rdat}, 9'h001);
    endtask
    task automatic s_addr();
        logic a;
        strap = 3'b010;
        mst_u.start();
        mst_u.wr_byte({DEV_ADDR_HI, 3'b101, 1'b0}, a);
        mst_u.stop();
        chk_bit(a, 1'b0);
        mst_u.hc(8);
        wr(8'hFA, 8'h11, 0);
        rd(8'hFA, rdat);
        chk({1'b0, rdat}, 9'h011);
    endtask
    task automatic s_user();
        wr(8'h00, 8'hC7, NVC);
        rd(8'h00, rdat);
        chk({1'b0, rdat}, 9'h0C7);
    endtask
    initial
    begin
        n_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        ext = 9'h000;
        strap = 3'b101;
        do_reset();
        s_nv();
        s_pu();
        s_see();
        s_addr();
        s_user();
        give_verdict();
    end
endmodule
